/* pkg/radio_cmd_pkg.sv */
// Purpose: shared constants for the serial command port
// Assumes: 20 MHz reference clock, 16-bit commands
// Notes:   command registers hold full 16-bit words incl. the code byte
package radio_cmd_pkg;

   // ---------------------------------------------------------------
   // command words
   // ---------------------------------------------------------------
   localparam int          CMD_W          = 16;
   localparam logic [7:0]  CODE_SETUP     = 8'h80;   // band and load setup
   localparam logic [7:0]  CODE_POWER     = 8'h82;   // power control
   localparam logic [15:0] SETUP_RESET    = 16'h8008;
   localparam logic [15:0] POWER_RESET    = 16'h8208;
   localparam logic [4:0]  LAST_BIT_IDX   = 5'h0F;   // count of the 16th bit

   // ---------------------------------------------------------------
   // band and load setup fields
   // ---------------------------------------------------------------
   localparam int TX_REG_ENABLE_BIT = 7;
   localparam int FIFO_ENABLE_BIT   = 6;
   localparam int BAND_SEL_LSB      = 4;
   localparam int LOAD_CAP_LSB      = 0;

   // ---------------------------------------------------------------
   // power control fields
   // ---------------------------------------------------------------
   localparam int RX_CHAIN_ON_BIT     = 7;
   localparam int BASEBAND_ON_BIT     = 6;
   localparam int TX_ON_BIT           = 5;
   localparam int SYNTH_ON_BIT        = 4;
   localparam int XTAL_ON_BIT         = 3;
   localparam int LOW_BATT_DET_ON_BIT = 2;
   localparam int WAKE_TIMER_ON_BIT   = 1;
   localparam int CLK_OUT_DISABLE_BIT = 0;

   // ---------------------------------------------------------------
   // event flags, packed into the top of the status word
   // ---------------------------------------------------------------
   localparam int         FLAG_W          = 7;
   localparam int         FLAG_TX_READY   = 6;
   localparam int         FLAG_FIFO_LEVEL = 5;
   localparam int         FLAG_POWER_ON   = 4;
   localparam int         FLAG_OVF_UNDER  = 3;
   localparam int         FLAG_WAKE       = 2;
   localparam int         FLAG_EXTERNAL   = 1;
   localparam int         FLAG_LOW_SUPPLY = 0;
   localparam logic [6:0] FLAG_RESET      = 7'h10;   // power-on event pending

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned POR_TIMEOUT_MS = 100;
   localparam int unsigned POR_CYCLES     = POR_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      ST_POR_WAIT = 4'h1,
      ST_IDLE     = 4'h2,
      ST_SHIFT    = 4'h4,
      ST_HOLD     = 4'h8
   } port_state_t;

endpackage

/* logic/pin_sync.sv */
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: pins are independent levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         ref_clk,  // reference clock
   input  wire logic         reset_n,  // sync reset, active low
   input  wire logic [W-1:0] pin_in,   // raw pins
   output logic      [W-1:0] pin_out   // synchronised pins
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_t;

   sync_t s_q;
   sync_t s_d;

   // shift one stage per clock
   always_comb begin
      s_d.meta   = pin_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s_q <= {RST_VAL, RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign pin_out = s_q.stable;

endmodule
`default_nettype wire

/* logic/sticky_flags.sv */
// Purpose: sticky event flags, set by hardware, cleared by the reader
// Assumes: set and clear are single-cycle pulses
// Notes:   a set in the clear cycle wins so no event is lost
`timescale 1ns/100ps
`default_nettype none
module sticky_flags #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         ref_clk,  // reference clock
   input  wire logic         reset_n,  // sync reset, active low
   input  wire logic [W-1:0] set_i,    // event pulses
   input  wire logic [W-1:0] clr_i,    // clear pulses
   output logic      [W-1:0] flag_o    // pending flags
);

   typedef struct packed {
      logic [W-1:0] flag;
   } flag_st_t;

   flag_st_t f_q;
   flag_st_t f_d;

   // set dominates clear
   always_comb begin
      f_d.flag = (f_q.flag & ~clr_i) | set_i;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         f_q.flag <= RST_VAL;
      end else begin
         f_q <= f_d;
      end
   end

   assign flag_o = f_q.flag;

endmodule
`default_nettype wire

/* logic/radio_serial_command_port.sv */
// Purpose: serial command port: shift in 16-bit commands, hold setup and
//          power registers, raise the active-low interrupt
// Assumes: link pins are asynchronous to ref_clk; event inputs are
//          single-cycle pulses on ref_clk
// Notes:   link clock is oversampled, so it must stay well below ref_clk/4
//
// Contract
// - bits are taken on each rising link clock while select is low
// - select high returns the shift logic to its start state
// - commands arrive most significant bit first
// - leading code bits pick the command, later bits are its parameters
// - power-on reset loads default values into every command register
// - commands are ignored during the power-on timeout
// - irq_out_n goes low while any enabled event is pending
// - transmit-ready, FIFO level, overflow and underrun raise interrupts
// - power-on, wake timeout, external pulse and low supply raise interrupts
// - FIFO events only while FIFO is enabled
// - transmit register events only while transmit register enabled
// - a one enables its function, except bits defined as disables
// - setup command code 80h carries enables, band and load capacitance
// - FIFO disabled routes received data and clock to output pins
// - band_sel selects 433, 868 or 915 MHz band
// - load_cap_sel steps crystal load from 8.5 to 16.0 pF
// - power command code 82h holds eight power enables
// - rx_chain_on powers the whole receiver; baseband can run alone
// - tx_on powers synth and amplifier, transmits if register enabled
// - synth, crystal, battery detector, wake timer enabled separately
// - clk_out_disable stops the microcontroller clock output
// - with tx_on and rx_chain_on both set, receive mode wins
`timescale 1ns/100ps
`default_nettype none
module radio_serial_command_port
   import radio_cmd_pkg::*;
#(
   parameter int unsigned POR_WAIT_CYCLES = POR_CYCLES
) (
   input  wire logic       ref_clk,           // 20 MHz reference clock
   input  wire logic       reset_n,           // power-on reset, active low
   input  wire logic       select_n,          // link select pin
   input  wire logic       serial_clk_pin,    // link clock pin
   input  wire logic       serial_in_pin,     // link data in
   output logic            serial_out_pin,    // status data out
   input  wire logic       ext_irq_in_n,      // external interrupt pin
   input  wire logic       tx_reg_ready_evt,  // transmit register empty
   input  wire logic       fifo_level_evt,    // FIFO reached its level
   input  wire logic       fifo_overflow_evt, // FIFO overflow
   input  wire logic       tx_underrun_evt,   // transmit register underrun
   input  wire logic       wake_timeout_evt,  // wake-up timer expired
   input  wire logic       low_supply_evt,    // supply below threshold
   input  wire logic       rx_data_in,        // recovered receive data
   input  wire logic       rx_clk_in,         // recovered receive clock
   output logic            irq_out_n,         // interrupt request, low active
   output logic            rx_data_out,       // data pin when FIFO is off
   output logic            data_clock_out,    // data clock when FIFO is off
   output logic            rx_to_fifo,        // received data goes to FIFO
   output logic            tx_reg_enable,     // internal transmit register on
   output logic [1:0]      band_sel,          // 01/10/11: 433/868/915 MHz
   output logic [3:0]      load_cap_sel,      // 8.5 pF + 0.5 pF per step
   output logic            rx_chain_on,       // receive mode, full chain
   output logic            baseband_on,       // receive baseband power
   output logic            synth_on,          // synthesizer power
   output logic            xtal_on,           // crystal oscillator power
   output logic            pa_on,             // power amplifier power
   output logic            tx_active,         // transmit mode
   output logic            tx_start,          // send from transmit register
   output logic            low_batt_det_on,   // low battery detector on
   output logic            wake_timer_on,     // wake-up timer on
   output logic            mcu_clk_out_en,    // microcontroller clock driven
   output logic            cmd_ready          // power-on timeout has ended
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   localparam int PORW = $clog2(POR_WAIT_CYCLES + 1);

   typedef struct packed {
      port_state_t       st;
      logic              sck_prev;
      logic              ext_prev;
      logic [15:0]       shift;
      logic [4:0]        cnt;
      logic              status_cmd;
      logic [15:0]       out_shift;
      logic [15:0]       setup;
      logic [15:0]       power;
      logic [PORW-1:0]   por_cnt;
      logic              irq_n;
      logic              data_out;
      logic              data_clock_out_out;
   } port_st_t;

   port_st_t         s_q;
   port_st_t         s_d;
   logic [3:0]       pins_s;
   logic             sel_n_s;
   logic             sck_s;
   logic             sdi_s;
   logic             ext_n_s;
   logic             sck_rise;
   logic             sck_fall;
   logic [15:0]      word;
   logic [FLAG_W-1:0] flags;
   logic [FLAG_W-1:0] flag_set;
   logic [FLAG_W-1:0] flag_clr;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // select idles high so the port starts deselected
   pin_sync #(
      .W       (4),
      .RST_VAL (4'h9)
   ) u_pin_sync (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .pin_in  ({select_n, serial_clk_pin, serial_in_pin, ext_irq_in_n}),
      .pin_out (pins_s)
   );

   assign sel_n_s  = pins_s[3];
   assign sck_s    = pins_s[2];
   assign sdi_s    = pins_s[1];
   assign ext_n_s  = pins_s[0];
   assign sck_rise = sck_s & ~s_q.sck_prev;
   assign sck_fall = ~sck_s & s_q.sck_prev;
   assign word     = {s_q.shift[14:0], sdi_s};

   // ---------------------------------------------------------------
   // event flags
   // ---------------------------------------------------------------
   // gate each event except the external pulse with the function that produces it
   always_comb begin
      flag_set = '0;
      flag_set[FLAG_TX_READY]   = tx_reg_ready_evt & s_q.setup[TX_REG_ENABLE_BIT];
      flag_set[FLAG_FIFO_LEVEL] = fifo_level_evt & s_q.setup[FIFO_ENABLE_BIT];
      flag_set[FLAG_OVF_UNDER]  = (fifo_overflow_evt & s_q.setup[FIFO_ENABLE_BIT])
                                | (tx_underrun_evt & s_q.setup[TX_REG_ENABLE_BIT]);
      flag_set[FLAG_WAKE]       = wake_timeout_evt & s_q.power[WAKE_TIMER_ON_BIT];
      flag_set[FLAG_EXTERNAL]   = ~ext_n_s & s_q.ext_prev;
      flag_set[FLAG_LOW_SUPPLY] = low_supply_evt & s_q.power[LOW_BATT_DET_ON_BIT];
   end

   // status read clears what it reports
   assign flag_clr = (s_q.st == ST_SHIFT && sck_rise && s_q.cnt == 5'h00 && !sdi_s)
                     ? flags : '0;

   // power-on flag comes out of reset already pending
   sticky_flags #(
      .W       (FLAG_W),
      .RST_VAL (FLAG_RESET)
   ) u_flags (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .set_i   (flag_set),
      .clr_i   (flag_clr),
      .flag_o  (flags)
   );

   // ---------------------------------------------------------------
   // command shifter and decoder
   // ---------------------------------------------------------------
   always_comb begin
      s_d          = s_q;
      s_d.sck_prev = sck_s;
      s_d.ext_prev = ext_n_s;
      // low while any enabled event pends
      s_d.irq_n    = ~|flags;
      // direct data pins only without FIFO
      s_d.data_out = ~s_q.setup[FIFO_ENABLE_BIT] & rx_data_in;
      s_d.data_clock_out_out = ~s_q.setup[FIFO_ENABLE_BIT] & rx_clk_in;
      // status bits leave on falling link clock
      if (sck_fall && s_q.status_cmd) begin
         s_d.out_shift = {s_q.out_shift[14:0], 1'b0};
      end
      case (s_q.st)
         ST_POR_WAIT: begin
            if (s_q.por_cnt == '0) begin
               s_d.st = ST_IDLE;
            end else begin
               s_d.por_cnt = s_q.por_cnt - 1'b1;
            end
         end
         ST_IDLE: begin
            s_d.cnt        = '0;
            s_d.status_cmd = 1'b0;
            if (!sel_n_s) begin
               s_d.st = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (sck_rise) begin
               // earlier bits move toward the top
               s_d.shift = word;
               s_d.cnt   = s_q.cnt + 5'h01;
               // a leading zero marks status read
               if (s_q.cnt == 5'h00 && !sdi_s) begin
                  s_d.status_cmd = 1'b1;
                  s_d.out_shift  = {flags, 9'h000};
               end
               // commit only on the sixteenth bit
               if (s_q.cnt == LAST_BIT_IDX) begin
                  s_d.st = ST_HOLD;
                  if (!s_q.status_cmd && word[15:8] == CODE_SETUP) begin
                     s_d.setup = word;
                  end else if (!s_q.status_cmd && word[15:8] == CODE_POWER) begin
                     s_d.power = word;
                  end
               end
            end
         end
         ST_HOLD: begin
            // extra bits in the frame are ignored
            s_d.cnt = s_q.cnt;
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
      if (sel_n_s && s_q.st != ST_POR_WAIT) begin
         s_d.st         = ST_IDLE;
         s_d.cnt        = '0;
         s_d.status_cmd = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s_q.st         <= ST_POR_WAIT;
         s_q.sck_prev   <= 1'b0;
         s_q.ext_prev   <= 1'b1;
         s_q.shift      <= '0;
         s_q.cnt        <= '0;
         s_q.status_cmd <= 1'b0;
         s_q.out_shift  <= '0;
         s_q.setup      <= SETUP_RESET;
         s_q.power      <= POWER_RESET;
         s_q.por_cnt    <= PORW'(POR_WAIT_CYCLES);
         s_q.irq_n      <= 1'b1;
         s_q.data_out   <= 1'b0;
         s_q.data_clock_out_out   <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign serial_out_pin = s_q.out_shift[15];
   assign irq_out_n      = s_q.irq_n;
   assign rx_data_out    = s_q.data_out;
   assign data_clock_out = s_q.data_clock_out_out;
   assign cmd_ready      = (s_q.st != ST_POR_WAIT);
   // ones enable, clock bit is a disable
   assign rx_to_fifo     = s_q.setup[FIFO_ENABLE_BIT];
   assign tx_reg_enable  = s_q.setup[TX_REG_ENABLE_BIT];
   assign band_sel       = s_q.setup[BAND_SEL_LSB +: 2];
   assign load_cap_sel   = s_q.setup[LOAD_CAP_LSB +: 4];
   assign rx_chain_on    = s_q.power[RX_CHAIN_ON_BIT];
   assign baseband_on    = s_q.power[RX_CHAIN_ON_BIT] | s_q.power[BASEBAND_ON_BIT];
   assign tx_active      = s_q.power[TX_ON_BIT] & ~s_q.power[RX_CHAIN_ON_BIT];
   assign pa_on          = tx_active;
   assign tx_start       = tx_active & s_q.setup[TX_REG_ENABLE_BIT];
   assign synth_on       = s_q.power[SYNTH_ON_BIT] | rx_chain_on | tx_active;
   assign xtal_on        = s_q.power[XTAL_ON_BIT] | rx_chain_on | tx_active;
   assign low_batt_det_on = s_q.power[LOW_BATT_DET_ON_BIT];
   assign wake_timer_on  = s_q.power[WAKE_TIMER_ON_BIT];
   assign mcu_clk_out_en = ~s_q.power[CLK_OUT_DISABLE_BIT];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_irq_follows_flag: assert property (|flags |=> !irq_out_n)
      else $error("irq not asserted for pending flag");
   a_irq_clears: assert property (flags == '0 |=> irq_out_n)
      else $error("irq asserted with no flag pending");
   a_fifo_gated: assert property (
      !s_q.setup[FIFO_ENABLE_BIT] && !flags[FLAG_FIFO_LEVEL] |=> !flags[FLAG_FIFO_LEVEL])
      else $error("fifo flag set while fifo disabled");
   a_txreg_gated: assert property (
      !s_q.setup[TX_REG_ENABLE_BIT] && !flags[FLAG_TX_READY] |=> !flags[FLAG_TX_READY])
      else $error("transmit flag set while register disabled");
   a_select_restart: assert property (
      sel_n_s && s_q.st != ST_POR_WAIT |=> s_q.st == ST_IDLE && s_q.cnt == 5'h00)
      else $error("shifter not reset by select high");
   a_por_ignore: assert property (s_q.st == ST_POR_WAIT |=> $stable(s_q.setup))
      else $error("register changed during power-on timeout");
   a_setup_load: assert property (
      s_q.st == ST_SHIFT && sck_rise && s_q.cnt == LAST_BIT_IDX && !sel_n_s
      && !s_q.status_cmd && s_q.shift[14:7] == CODE_SETUP
      |=> s_q.setup == {$past(s_q.shift[14:0]), $past(sdi_s)})
      else $error("setup word not loaded msb first");
   a_full_frame: assert property (
      $changed(s_q.power) |-> $past(s_q.cnt) == LAST_BIT_IDX && $past(sck_rise))
      else $error("power register changed before sixteenth bit");
   a_rx_priority: assert property (rx_chain_on |-> !tx_active && !pa_on)
      else $error("transmit active in receive mode");
   a_ext_pulse: assert property (
      $fell(ext_irq_in_n) ##1 !ext_irq_in_n [*3] |-> ##[0:2] flags[FLAG_EXTERNAL])
      else $error("external pulse not flagged");
   a_defaults: assert property ($rose(cmd_ready) |-> s_q.setup == SETUP_RESET
      && s_q.power == POWER_RESET)
      else $error("registers not at defaults after timeout");
   a_status_first: assert property (
      s_q.st == ST_SHIFT && sck_rise && s_q.cnt == 5'h00 && !sdi_s
      |=> serial_out_pin == $past(flags[FLAG_TX_READY]))
      else $error("status word not captured on first bit");
   a_event_kept: assert property (flag_set != '0
      |=> (flags & $past(flag_set)) == $past(flag_set))
      else $error("event lost in a clear cycle");

   c_setup_write: cover property ($changed(s_q.setup));
   c_power_write: cover property ($changed(s_q.power));
   c_status_read: cover property (flag_clr != '0);
   c_irq_low:     cover property ($fell(irq_out_n));

endmodule
`default_nettype wire

/* dv/host_link_model.sv */
// Purpose: host side of the serial command link
// Assumes: ref_clk paces the host; link clock is high four and low six ref_clk cycles
// Notes:   link clock rests low between frames; data shows inverse when idle
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
   input  wire logic ref_clk,        // pacing clock
   input  wire logic serial_out_pin, // status bit from device
   output logic      select_n,       // link select
   output logic      serial_clk_pin, // link clock
   output logic      serial_in_pin   // link data
);
   initial begin
      select_n = 1'b1;
      serial_clk_pin = 1'b0;
      serial_in_pin = 1'b0;
   end
   // ------------------------------------------------------------
   // frame transfer
   // ------------------------------------------------------------
   // msb first, status word
   task automatic send(input logic [15:0] w, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge ref_clk) select_n <= 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         @(posedge ref_clk) serial_in_pin <= w[i];
         repeat (4) @(posedge ref_clk);
         serial_clk_pin <= 1'b1;
         repeat (4) @(posedge ref_clk);
         serial_clk_pin <= 1'b0;
         // sample early in low phase, before this fall's shift lands
         repeat (2) @(negedge ref_clk);
         rd[i] = serial_out_pin;
      end
      @(posedge ref_clk) select_n <= 1'b1;
      serial_in_pin <= ~serial_in_pin;
      repeat (8) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

/* dv/radio_serial_command_port_test.sv */
// Purpose: self-checking bench for the serial command port
// Assumes: short power-on wait through POR_WAIT_CYCLES
// Notes:   expected outputs come from the written setup and power bytes
`timescale 1ns/100ps
`default_nettype none
module radio_serial_command_port_test;
   import radio_cmd_pkg::*;
   logic ref_clk = 1'b0, reset_n = 1'b0, ext_irq_in_n = 1'b1;
   logic tx_reg_ready_evt = 1'b0, fifo_level_evt = 1'b0, fifo_overflow_evt = 1'b0;
   logic tx_underrun_evt = 1'b0, wake_timeout_evt = 1'b0, low_supply_evt = 1'b0;
   logic rx_data_in = 1'b0, rx_clk_in = 1'b0;
   logic select_n, serial_clk_pin, serial_in_pin, serial_out_pin, irq_out_n;
   logic rx_data_out, data_clock_out, rx_to_fifo, tx_reg_enable, rx_chain_on;
   logic baseband_on, synth_on, xtal_on, pa_on, tx_active, tx_start, cmd_ready;
   logic low_batt_det_on, wake_timer_on, mcu_clk_out_en;
   logic [1:0] band_sel;
   logic [3:0] load_cap_sel;
   logic [15:0] rd;
   logic [7:0] s, p, b;
   logic [31:0] outs;
   int failures = 0, tests_run = 0, cycles = 0, seed = 54;

   always #25 ref_clk = ~ref_clk;
   radio_serial_command_port #(.POR_WAIT_CYCLES(200)) u_radio_serial_command_port (.*);
   host_link_model u_host_link_model (.*);
   assign outs = {14'h0000, tx_reg_enable, rx_to_fifo, band_sel, load_cap_sel, rx_chain_on,
                  baseband_on, synth_on, xtal_on, pa_on, tx_active, tx_start,
                  low_batt_det_on, wake_timer_on, mcu_clk_out_en};

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] exp_outs(input logic [7:0] s, input logic [7:0] p);
      logic t;
      t = p[5] & ~p[7];
      return {14'h0000, s[7], s[6], s[5:4], s[3:0], p[7], p[7] | p[6], p[4] | p[7] | t,
              p[3] | p[7] | t, t, t, t & s[7], p[2], p[1], ~p[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] v);
      u_host_link_model.send({c, v}, 16, rd);
      if (c == CODE_SETUP) s = v;
      if (c == CODE_POWER) p = v;
      chk(outs, exp_outs(s, p));
   endtask
   // all six event pulses plus an external low pulse
   task automatic pulse_all();
      @(posedge ref_clk);
      {tx_reg_ready_evt, fifo_level_evt, fifo_overflow_evt} <= 3'h7;
      {tx_underrun_evt, wake_timeout_evt, low_supply_evt} <= 3'h7;
      ext_irq_in_n <= 1'b0;
      @(posedge ref_clk);
      {tx_reg_ready_evt, fifo_level_evt, fifo_overflow_evt} <= 3'h0;
      {tx_underrun_evt, wake_timeout_evt, low_supply_evt} <= 3'h0;
      repeat (4) @(posedge ref_clk);
      ext_irq_in_n <= 1'b1;
      repeat (6) @(negedge ref_clk);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // hang guard, well above the expected run of some 3800 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      s = SETUP_RESET[7:0];
      p = POWER_RESET[7:0];
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(outs, exp_outs(s, p));
      chk({31'h0, irq_out_n}, 0);
      u_host_link_model.send({CODE_SETUP, 8'hFF}, 16, rd);
      chk(outs, exp_outs(s, p));
      for (int i = 0; i < 400 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
      chk({31'h0, cmd_ready}, 1);
      $display("reset test done");
      for (int i = 0; i < 12; i++) begin
         b = (i < 3) ? 8'hA0 + 8'(i) : 8'($random(seed));
         cmd(i[0] ? CODE_SETUP : CODE_POWER, (i == 1) ? 8'hB0 : b);
      end
      u_host_link_model.send({CODE_SETUP, ~s}, 12, rd);
      chk(outs, exp_outs(s, p));
      u_host_link_model.send(16'hA680, 16, rd);
      chk(outs, exp_outs(s, p));
      $display("command test done");
      rx_data_in <= 1'b1;
      rx_clk_in <= 1'b1;
      cmd(CODE_SETUP, 8'hC8); // board holds the fsk pin high here
      chk({30'h0, rx_data_out, data_clock_out}, 0);
      cmd(CODE_POWER, 8'h0E);
      u_host_link_model.send(16'h0000, 16, rd);
      chk(rd, 16'h2000);
      chk({31'h0, irq_out_n}, 1);
      pulse_all();
      chk({31'h0, irq_out_n}, 0);
      u_host_link_model.send(16'h0000, 16, rd);
      chk(rd, 16'hDE00);
      $display("event test done");
      cmd(CODE_SETUP, 8'h00);
      chk({30'h0, rx_data_out, data_clock_out}, 3);
      cmd(CODE_POWER, 8'h08);
      pulse_all();
      u_host_link_model.send(16'h0000, 16, rd);
      chk(rd, 16'h0400);
      $display("gating test done");
      conclude();
   end
endmodule
`default_nettype wire
